// ### dv/smiee_pm_model.sv
// Power-management side model driving the request pin
`timescale 1ns/1ns
`default_nettype none

module smiee_pm_model
(
	// Clock
	input  wire logic clk,
	// Request pin
	output var  logic mgmt_irq_req_n
);
	initial mgmt_irq_req_n = 1'h1;

	// Low for lo cycles, then high for three before the next edge
	task automatic fire(input int lo);
		@(posedge clk);
		#1 mgmt_irq_req_n = 1'h0;
		repeat (lo) @(posedge clk);
		#1 mgmt_irq_req_n = 1'h1;
		repeat (3) @(posedge clk);
		#1;
	endtask
endmodule

`default_nettype wire

// ### dv/system_mgmt_interrupt_entry_exit_tb.sv
// Self-checking bench for the management entry and exit controller
`timescale 1ns/1ns
`default_nettype none

module system_mgmt_interrupt_entry_exit_tb;
	import smiee_pkg::*;
	logic        clk, req_n, act_n, take;
	logic        srst;
	logic        ext, ib, rb, lk, rs;
	smiee_core_s stat;
	smiee_ctrl_s ctrl;
	int          mismatches = 0, tests_run = 0, cycles = 0;
	int          n_ent = 0, n_take = 0;

	assign stat = '{ib, rb, lk, rs};
	smiee_pm_model pm (.clk(clk), .mgmt_irq_req_n(req_n));
	smiee_ctrl dut (.clk(clk), .srst(srst), .mgmt_irq_req_n(req_n),
		.ext_irq_req(ext), .core_stat(stat), .core_ctrl_ff(ctrl),
		.ext_irq_take_ff(take), .mgmt_session_active_n(act_n));

	initial
	begin
		clk = 1'h0;
		forever #2 clk = ~clk;
	end

	// Event counters and hang guard
	always @(posedge clk)
	begin
		cycles++;
		if (ctrl.enter_mgmt === 1'h1)
			n_ent++;
		if (take === 1'h1)
			n_take++;
		if (cycles == 2000)
		begin
			mismatches++;
			end_sim();
		end
	end

	task automatic cyc(input int n);
		repeat (n) @(posedge clk);
		#1;
	endtask

	task automatic chk(input string nm, input logic [7:0] e, g);
		tests_run++;
		if (g !== e)
			$display("mismatch %s exp %0h got %0h", nm, e, g);
		if (g !== e)
			mismatches++;
	endtask

	task automatic resume();
		rs = 1'h1;
		cyc(1);
		rs = 1'h0;
	endtask

	task automatic t_basic();
		int e0 = n_ent;
		ib = 1'h1;
		pm.fire(6);
		chk("active_n", 1'h0, act_n);
		chk("entries", 8'h1, 8'(n_ent - e0));
		chk("mode", 1'h1, ctrl.mgmt_mode);
		cyc(4);
		chk("active_n held", 1'h0, act_n);
		resume();
		chk("active_n", 1'h1, act_n);
		chk("mode", 1'h0, ctrl.mgmt_mode);
		cyc(3);
		$display("test basic done");
	endtask

	task automatic t_hold();
		ib = 1'h0;
		pm.fire(3);
		cyc(4);
		chk("no boundary", 1'h1, act_n);
		lk = 1'h1;
		ib = 1'h1;
		cyc(6);
		chk("locked", 1'h1, act_n);
		lk = 1'h0;
		cyc(2);
		chk("unlocked", 1'h0, act_n);
		resume();
		ib = 1'h0;
		rb = 1'h1;
		cyc(3);
		pm.fire(3);
		chk("rep iter", 1'h0, act_n);
		resume();
		rb = 1'h0;
		cyc(3);
		$display("test hold done");
	endtask

	task automatic t_second();
		int e0 = n_ent;
		ib = 1'h1;
		pm.fire(3);
		pm.fire(3);
		cyc(4);
		chk("one session", 8'h1, 8'(n_ent - e0));
		resume();
		chk("left session", 1'h1, act_n);
		cyc(4);
		chk("second taken", 1'h0, act_n);
		chk("entries", 8'h2, 8'(n_ent - e0));
		resume();
		cyc(3);
		$display("test second done");
	endtask

	// Request edge lands in the very cycle of the resume
	task automatic t_rsm_edge();
		int e0 = n_ent;
		ib = 1'h1;
		pm.fire(3);
		fork
			pm.fire(3);
			begin
				cyc(3);
				resume();
			end
		join
		chk("edge at resume", 1'h0, act_n);
		chk("entries", 8'h2, 8'(n_ent - e0));
		resume();
		cyc(3);
		$display("test resume edge done");
	endtask

	task automatic t_prio();
		int t0 = n_take;
		ext = 1'h1;
		cyc(1);
		ext = 1'h0;
		cyc(2);
		chk("ext alone", 8'h1, 8'(n_take - t0));
		ib = 1'h0;
		pm.fire(3);
		ext = 1'h1;
		ib = 1'h1;
		cyc(1);
		ib = 1'h0;
		cyc(2);
		chk("ext lost", 8'h1, 8'(n_take - t0));
		chk("mgmt won", 1'h0, act_n);
		chk("mask ext", 1'h1, ctrl.mask_ext_irq);
		ext = 1'h0;
		resume();
		$display("test prio done");
	endtask

	task automatic end_sim();
		$display("checks %0d mismatches %0d", tests_run, mismatches);
		if (mismatches == 0 && tests_run > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask

	initial
	begin
		srst = 1'h1;
		ext = 1'h0;
		ib = 1'h0;
		rb = 1'h0;
		lk = 1'h0;
		rs = 1'h0;
		cyc(2);
		srst = 1'h0;
		chk("reset active_n", 1'h1, act_n);
		chk("reset ctrl", 3'h0, ctrl);
		cyc(3);
		t_basic();
		t_hold();
		t_second();
		t_rsm_edge();
		t_prio();
		end_sim();
	end
endmodule

`default_nettype wire

// ### rtl/smiee_ctrl.sv
// Management interrupt request capture, entry and exit sequencing
//
// Behaviour
// RULE_01 - Falling edge of low-true request sets a pending flag held until serviced.
// RULE_02 - Pending request enters management mode only after current instruction finishes.
// RULE_03 - Request sampled at instruction boundaries and between repeat-string iterations.
// RULE_04 - Management request outranks every other external interrupt.
// RULE_05 - Never taken inside locked bus sequence or during an active session.
// RULE_06 - Second request falling during a session is recorded, not dropped.
// RULE_07 - Recorded second request is serviced only after the resume instruction.
// RULE_08 - Active output goes low at entry and stays low until resume executes.
// RULE_09 - Request pin is synchronised before edge detection; one set per edge.
`timescale 1ns/1ns
`default_nettype none

module smiee_ctrl
	import smiee_pkg::*;
(
	// Clock and reset
	input  wire logic                  clk,
	input  wire logic                  srst,
	// Request pin from power-management logic
	input  wire logic                  mgmt_irq_req_n,
	// Other external interrupt request from the interrupt controller
	input  wire logic                  ext_irq_req,
	// Core status
	input  wire smiee_pkg::smiee_core_s core_stat,
	// Core control
	output var  smiee_pkg::smiee_ctrl_s core_ctrl_ff,
	output var  logic                  ext_irq_take_ff,
	// Session indication pin
	output var  logic                  mgmt_session_active_n
);
	import smiee_pkg::*;

	// ------------------------------------------------------------
	// Request synchroniser and edge detect
	// ------------------------------------------------------------
	logic [SYNC_STAGES-1:0] req_sync_ff;
	logic                   req_prev_ff;
	logic                   req_fall;

	// RULE_09 synchronise first
	always_ff @(posedge clk)
	begin
		if (srst)
		begin
			req_sync_ff <= {SYNC_STAGES{RST_REQ_N}};
			req_prev_ff <= RST_REQ_N;
		end
		else
		begin
			req_sync_ff <= {req_sync_ff[SYNC_STAGES-2:0], mgmt_irq_req_n};
			req_prev_ff <= req_sync_ff[SYNC_STAGES-1];
		end
	end

	// RULE_01 falling edge
	assign req_fall = req_prev_ff & ~req_sync_ff[SYNC_STAGES-1];

	// ------------------------------------------------------------
	// Session state machine
	// ------------------------------------------------------------
	smiee_state_e state_ff;
	smiee_state_e nxt_state;
	logic         pend_ff;
	logic         pend2_ff;
	logic         take_ok;
	logic         take;
	logic         resume_from_mgmt;

	// RULE_02 boundary only
	// RULE_03 iteration boundaries too
	// RULE_05 no locked cycle
	assign take_ok = (core_stat.instr_boundary | core_stat.rep_iter_boundary)
		& ~core_stat.locked_cycle;
	// RULE_05 not during a session
	assign take = pend_ff & take_ok & (state_ff == SMIEE_IDLE);
	// RULE_07 resume in session
	assign resume_from_mgmt = (state_ff == SMIEE_MGMT) & core_stat.resume_exec;

	always_comb
	begin
		nxt_state = state_ff;
		case (state_ff)
			SMIEE_IDLE:
				if (take)
					nxt_state = SMIEE_ENTER;
			SMIEE_ENTER:
				nxt_state = SMIEE_MGMT;
			SMIEE_MGMT:
				if (core_stat.resume_exec)
					nxt_state = SMIEE_IDLE;
			default:
				nxt_state = SMIEE_IDLE;
		endcase
	end

	always_ff @(posedge clk)
	begin
		if (srst)
			state_ff <= SMIEE_IDLE;
		else
			state_ff <= nxt_state;
	end

	// ------------------------------------------------------------
	// Pending flags
	// ------------------------------------------------------------
	// RULE_01 hold pending; an edge in the take cycle stays pending
	always_ff @(posedge clk)
	begin
		if (srst)
			pend_ff <= 1'b0;
		// An edge in the resume cycle goes straight to pending
		else if (req_fall && (state_ff == SMIEE_IDLE || resume_from_mgmt))
			pend_ff <= 1'b1;
		// RULE_07 released into pending only after resume
		else if (resume_from_mgmt && pend2_ff)
			pend_ff <= 1'b1;
		else if (take)
			pend_ff <= 1'b0;
	end

	// RULE_06 record second request
	always_ff @(posedge clk)
	begin
		if (srst)
			pend2_ff <= 1'b0;
		else if (req_fall && state_ff != SMIEE_IDLE && !resume_from_mgmt)
			pend2_ff <= 1'b1;
		else if (resume_from_mgmt)
			pend2_ff <= 1'b0;
	end

	// ------------------------------------------------------------
	// Outputs
	// ------------------------------------------------------------
	// RULE_08 low from entry to resume
	always_ff @(posedge clk)
	begin
		if (srst)
			mgmt_session_active_n <= RST_ACTIVE_N;
		else if (take)
			mgmt_session_active_n <= 1'b0;
		else if (state_ff == SMIEE_MGMT && core_stat.resume_exec)
			mgmt_session_active_n <= 1'b1;
	end

	// RULE_04 management request wins
	always_ff @(posedge clk)
	begin
		if (srst)
		begin
			core_ctrl_ff    <= '0;
			ext_irq_take_ff <= 1'b0;
		end
		else
		begin
			core_ctrl_ff.enter_mgmt   <= take;
			core_ctrl_ff.mgmt_mode    <= (nxt_state != SMIEE_IDLE);
			core_ctrl_ff.mask_ext_irq <= pend_ff | (nxt_state != SMIEE_IDLE);
			ext_irq_take_ff <= ext_irq_req & core_stat.instr_boundary
				& ~core_stat.locked_cycle & ~pend_ff & ~take
				& (state_ff == SMIEE_IDLE);
		end
	end

	// ------------------------------------------------------------
	// Assertions
	// ------------------------------------------------------------
	sequence s_entry;
		take ##1 (state_ff == SMIEE_ENTER);
	endsequence

	sequence s_in_mgmt;
		(state_ff == SMIEE_MGMT) && !core_stat.resume_exec;
	endsequence

	property p_edge_pend;
		@(posedge clk) disable iff (srst)
		(req_fall && state_ff == SMIEE_IDLE) |=> pend_ff;
	endproperty
	a_edge_pend: assert property (p_edge_pend) // RULE_01
		else $error("edge not pending");

	property p_boundary;
		@(posedge clk) disable iff (srst)
		take |-> (core_stat.instr_boundary || core_stat.rep_iter_boundary);
	endproperty
	a_boundary: assert property (p_boundary) // RULE_02
		else $error("entry off boundary");

	property p_sample;
		@(posedge clk) disable iff (srst)
		(pend_ff && state_ff == SMIEE_IDLE && core_stat.rep_iter_boundary
			&& !core_stat.locked_cycle) |-> s_entry;
	endproperty
	a_sample: assert property (p_sample) // RULE_03
		else $error("iteration sample missed");

	property p_prio;
		@(posedge clk) disable iff (srst)
		(pend_ff || take) |=> !ext_irq_take_ff;
	endproperty
	a_prio: assert property (p_prio) // RULE_04
		else $error("external irq beat management");

	property p_lock;
		@(posedge clk) disable iff (srst)
		(core_stat.locked_cycle || state_ff != SMIEE_IDLE) |-> !take;
	endproperty
	a_lock: assert property (p_lock) // RULE_05
		else $error("entry in lock or session");

	property p_second;
		@(posedge clk) disable iff (srst)
		(req_fall && state_ff == SMIEE_MGMT && !core_stat.resume_exec)
			|=> pend2_ff;
	endproperty
	a_second: assert property (p_second) // RULE_06
		else $error("second request lost");

	property p_rsm_edge;
		@(posedge clk) disable iff (srst)
		(req_fall && resume_from_mgmt) |=> (pend_ff && !pend2_ff);
	endproperty
	a_rsm_edge: assert property (p_rsm_edge) // RULE_06
		else $error("edge at resume lost");

	property p_after_rsm;
		@(posedge clk) disable iff (srst)
		(s_in_mgmt ##0 pend2_ff) |=> !take;
	endproperty
	a_after_rsm: assert property (p_after_rsm) // RULE_07
		else $error("second served in session");

	property p_act;
		@(posedge clk) disable iff (srst)
		s_entry |-> !mgmt_session_active_n ##1 !mgmt_session_active_n;
	endproperty
	a_act: assert property (p_act) // RULE_08
		else $error("active not low in entry");

	property p_act_rel;
		@(posedge clk) disable iff (srst)
		(state_ff == SMIEE_MGMT && core_stat.resume_exec)
			|=> mgmt_session_active_n;
	endproperty
	a_act_rel: assert property (p_act_rel) // RULE_08
		else $error("active not released");

	property p_once;
		@(posedge clk) disable iff (srst)
		req_fall |=> !req_fall;
	endproperty
	a_once: assert property (p_once) // RULE_09
		else $error("double edge");

endmodule

`default_nettype wire

// ### rtl/smiee_pkg.sv
// Package for the management interrupt entry and exit controller
package smiee_pkg;

	// Synchroniser depth on the request pin
	localparam int unsigned SYNC_STAGES = 2;

	// Reset values
	localparam logic RST_REQ_N    = 1'b1;
	localparam logic RST_ACTIVE_N = 1'b1;

	// Session state
	typedef enum logic [1:0]
	{
		SMIEE_IDLE  = 2'b00,
		SMIEE_ENTER = 2'b01,
		SMIEE_MGMT  = 2'b10
	} smiee_state_e;

	// Core status presented by the execution pipeline
	typedef struct packed
	{
		logic instr_boundary;
		logic rep_iter_boundary;
		logic locked_cycle;
		logic resume_exec;
	} smiee_core_s;

	// Entry request, mode flag and external interrupt mask towards the core
	typedef struct packed
	{
		logic enter_mgmt;
		logic mgmt_mode;
		logic mask_ext_irq;
	} smiee_ctrl_s;

endpackage
